// >>> hdl/mpc_pkg.sv
package mpc_pkg;
    // Register selects on the internal access port
    localparam logic [1:0] MPC_SEL_MON2_CFG = 2'h0;
    localparam logic [1:0] MPC_SEL_POWER_ENABLE_CONTROL = 2'h1;
    localparam logic [1:0] MPC_SEL_CLK_MON = 2'h2;
    // Monitor 2 response config fields
    localparam int MPC_M2_OV_SAFE = 3;
    localparam int MPC_M2_UV_SAFE = 2;
    localparam int MPC_M2_UV_RST = 1;
    localparam int MPC_M2_OV_RST = 0;
    localparam logic [7:0] MPC_M2_MASK = 8'h0f;
    // Power control fields
    localparam int MPC_PC_MON2_ON = 5;
    localparam int MPC_PC_MON1_ON = 4;
    localparam int MPC_PC_BOOST_ON = 3;
    localparam int MPC_PC_LVBUCK_ON = 1;
    localparam logic [7:0] MPC_PC_MASK = 8'h3a;
    localparam logic [7:0] MPC_PC_KEEP = 8'h30;
    localparam logic [7:0] MPC_PC_RST = 8'h0a;
    // Clock monitor control
    localparam logic [7:0] MPC_CM_MASK = 8'h5e;
    localparam logic [7:0] MPC_CM_RST = 8'h5c;
endpackage : mpc_pkg

// >>> hdl/mpc_reg8.sv
`timescale 1ns/1ns
`default_nettype none
module mpc_reg8 #(
    parameter logic [7:0] MASK = 8'hff
) (
    input wire logic clk,
    input wire logic load,
    input wire logic [7:0] load_val,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] clr_bits,
    output logic [7:0] q
);
    logic [7:0] next_q;
    always_comb begin
        next_q = q;
        if (load) begin
            next_q = load_val;
        end else if (wr_en) begin
            next_q = wr_data;
        end
        // Hardware clears win over a same-cycle write
        next_q = next_q & ~clr_bits & MASK;
    end
    always_ff @(posedge clk) begin
        q <= next_q;
    end
endmodule : mpc_reg8
`default_nettype wire

// >>> hdl/mpc_regs.sv
// Functional notes
// - Monitor 2 config writes only in diagnostic state with config lock clear.
// - Bit 3 set: monitor 2 overvoltage sends device to safe state.
// - Bit 2 set: monitor 2 undervoltage sends device to safe state.
// - Bit 1 set: undervoltage sends to reset, beating safe; default from nonvolatile bit.
// - Bit 0 set: overvoltage sends to reset, beating safe; default 0.
// - Monitor 2 config set only by power-on reset.
// - Power control set by power-on reset and reset-state entry, minus kept bits.
// - Power control writes only with control lock clear.
// - Pre-regulator on by default, register-proof, driven by wake and wake latch.
// - Pre-regulator restarts after protection-off once restart conditions hold.
// - Bit 5 enables second monitor, bit 4 first; kept over reset state.
// - Bit 3 boost enable, default 1, cleared on fault or safe entry.
// - Bit 1 buck enable, default 1, cleared on fault or safe entry.
// - Clock monitor control: fully reloaded on power-on reset and reset-state entry, no kept bits, writes gated by control lock.
`timescale 1ns/1ns
`default_nettype none
module mpc_regs (
    input wire logic clk,
    input wire logic srst,
    input wire logic nv_uv_reset_default,
    input wire logic nv_mon_on_default,
    input wire logic in_diag_state,
    input wire logic reset_state_entry,
    input wire logic safe_state_entry,
    input wire logic cfg_lock,
    input wire logic ctrl_lock,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [1:0] reg_sel,
    input wire logic [7:0] wr_data,
    input wire logic mon2_ov_event,
    input wire logic mon2_uv_event,
    input wire logic boost_fault,
    input wire logic lv_buck_fault,
    input wire logic wake,
    input wire logic wake_latch,
    input wire logic prereg_protect_off,
    input wire logic prereg_restart_ok,
    output logic [7:0] rd_data,
    output logic mon2_to_safe,
    output logic mon2_to_reset,
    output logic first_supply_monitor_on,
    output logic second_supply_monitor_on,
    output logic boost_on,
    output logic lv_buck_on,
    output logic [7:0] clk_mon_ctrl,
    output logic prereg_on
);
    import mpc_pkg::*;

    logic [7:0] second_monitor_response_config;
    logic [7:0] power_enable_control;
    logic wr_cfg_ok, wr_pc_ok, wr_cm_ok;
    logic [7:0] cfg_por_val, pc_load_val, pc_clr;
    logic pc_load, prereg_tripped, next_prereg_tripped;
    logic [7:0] next_rd_data;
    logic next_mon2_to_safe, next_mon2_to_reset;

    always_comb begin
        wr_cfg_ok = wr_strobe && reg_sel == MPC_SEL_MON2_CFG && in_diag_state && !cfg_lock;
        wr_pc_ok = wr_strobe && reg_sel == MPC_SEL_POWER_ENABLE_CONTROL && !ctrl_lock;
        wr_cm_ok = wr_strobe && reg_sel == MPC_SEL_CLK_MON && !ctrl_lock;
        cfg_por_val = 8'h00;
        cfg_por_val[MPC_M2_UV_RST] = nv_uv_reset_default;
        pc_load = srst || reset_state_entry;
        // Monitor enables survive reset-state entry, so only power-on loads them
        pc_load_val = srst ? (MPC_PC_RST | ({8{nv_mon_on_default}} & MPC_PC_KEEP))
                           : ((power_enable_control & MPC_PC_KEEP) | MPC_PC_RST);
        pc_clr = 8'h00;
        pc_clr[MPC_PC_BOOST_ON] = !srst && (boost_fault || safe_state_entry);
        pc_clr[MPC_PC_LVBUCK_ON] = !srst && (lv_buck_fault || safe_state_entry);
    end

    mpc_reg8 #(.MASK(MPC_M2_MASK)) u_cfg (
        .clk(clk),
        .load(srst),
        .load_val(cfg_por_val),
        .wr_en(wr_cfg_ok),
        .wr_data(wr_data),
        .clr_bits(8'h00),
        .q(second_monitor_response_config)
    );

    mpc_reg8 #(.MASK(MPC_PC_MASK)) u_pc (
        .clk(clk),
        .load(pc_load),
        .load_val(pc_load_val),
        .wr_en(wr_pc_ok),
        .wr_data(wr_data),
        .clr_bits(pc_clr),
        .q(power_enable_control)
    );

    mpc_reg8 #(.MASK(MPC_CM_MASK)) u_cm (
        .clk(clk),
        .load(pc_load),
        .load_val(MPC_CM_RST),
        .wr_en(wr_cm_ok),
        .wr_data(wr_data),
        .clr_bits(8'h00),
        .q(clk_mon_ctrl)
    );

    always_comb begin
        next_rd_data = rd_data;
        if (rd_strobe) begin
            case (reg_sel)
                MPC_SEL_MON2_CFG: next_rd_data = second_monitor_response_config;
                MPC_SEL_POWER_ENABLE_CONTROL: next_rd_data = power_enable_control;
                MPC_SEL_CLK_MON: next_rd_data = clk_mon_ctrl;
                default: next_rd_data = 8'h00;
            endcase
        end
        // Reset wins over safe on the same event
        next_mon2_to_reset = (mon2_uv_event && second_monitor_response_config[MPC_M2_UV_RST])
                          || (mon2_ov_event && second_monitor_response_config[MPC_M2_OV_RST]);
        next_mon2_to_safe = !next_mon2_to_reset
                          && ((mon2_ov_event && second_monitor_response_config[MPC_M2_OV_SAFE])
                          || (mon2_uv_event && second_monitor_response_config[MPC_M2_UV_SAFE]));
        // Protection trip latched until restart is allowed
        next_prereg_tripped = prereg_protect_off || (prereg_tripped && !prereg_restart_ok);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data <= 8'h00;
            mon2_to_safe <= 1'b0;
            mon2_to_reset <= 1'b0;
            prereg_tripped <= 1'b0;
        end else begin
            rd_data <= next_rd_data;
            mon2_to_safe <= next_mon2_to_safe;
            mon2_to_reset <= next_mon2_to_reset;
            prereg_tripped <= next_prereg_tripped;
        end
    end

    assign first_supply_monitor_on = power_enable_control[MPC_PC_MON1_ON];
    assign second_supply_monitor_on = power_enable_control[MPC_PC_MON2_ON];
    assign boost_on = power_enable_control[MPC_PC_BOOST_ON];
    assign lv_buck_on = power_enable_control[MPC_PC_LVBUCK_ON];
    // No register bit reaches this enable by design
    assign prereg_on = (wake || wake_latch) && !prereg_tripped;

    cfg_lock_a: assert property (@(posedge clk) disable iff (srst)
        (wr_strobe && reg_sel == MPC_SEL_MON2_CFG && (cfg_lock || !in_diag_state))
        |=> $stable(second_monitor_response_config))
        else $error("config changed under lock");
    ctrl_lock_a: assert property (@(posedge clk) disable iff (srst)
        (wr_strobe && reg_sel == MPC_SEL_POWER_ENABLE_CONTROL && ctrl_lock && !reset_state_entry
         && !boost_fault && !lv_buck_fault && !safe_state_entry)
        |=> $stable(power_enable_control))
        else $error("power control changed under lock");
    ov_safe_a: assert property (@(posedge clk) disable iff (srst)
        (mon2_ov_event && !mon2_uv_event && second_monitor_response_config[MPC_M2_OV_SAFE]
         && !second_monitor_response_config[MPC_M2_OV_RST]) |=> mon2_to_safe)
        else $error("overvoltage safe missed");
    uv_safe_a: assert property (@(posedge clk) disable iff (srst)
        (mon2_uv_event && !mon2_ov_event && second_monitor_response_config[MPC_M2_UV_SAFE]
         && !second_monitor_response_config[MPC_M2_UV_RST]) |=> mon2_to_safe)
        else $error("undervoltage safe missed");
    uv_reset_a: assert property (@(posedge clk) disable iff (srst)
        (mon2_uv_event && second_monitor_response_config[MPC_M2_UV_RST]) |=> mon2_to_reset && !mon2_to_safe)
        else $error("undervoltage reset priority broken");
    ov_reset_a: assert property (@(posedge clk) disable iff (srst)
        (mon2_ov_event && second_monitor_response_config[MPC_M2_OV_RST]) |=> mon2_to_reset && !mon2_to_safe)
        else $error("overvoltage reset priority broken");
    cfg_resv_a: assert property (@(posedge clk) disable iff (srst)
        second_monitor_response_config[7:4] == 4'h0)
        else $error("reserved config bits set");
    keep_mon_a: assert property (@(posedge clk) disable iff (srst)
        reset_state_entry
        |=> (power_enable_control & MPC_PC_KEEP) == ($past(power_enable_control) & MPC_PC_KEEP))
        else $error("monitor enables lost on reset entry");
    boost_clr_a: assert property (@(posedge clk) disable iff (srst)
        (boost_fault || safe_state_entry) |=> !boost_on)
        else $error("boost enable not cleared");
    buck_clr_a: assert property (@(posedge clk) disable iff (srst)
        (lv_buck_fault || safe_state_entry) |=> !lv_buck_on)
        else $error("buck enable not cleared");
    ov_quiet_a: assert property (@(posedge clk) disable iff (srst)
        (mon2_ov_event && !mon2_uv_event && !second_monitor_response_config[MPC_M2_OV_SAFE]) |=> !mon2_to_safe)
        else $error("overvoltage safe without enable");
    uv_quiet_a: assert property (@(posedge clk) disable iff (srst)
        (mon2_uv_event && !mon2_ov_event && !second_monitor_response_config[MPC_M2_UV_SAFE]) |=> !mon2_to_safe)
        else $error("undervoltage safe without enable");
    idle_quiet_a: assert property (@(posedge clk) disable iff (srst)
        (!mon2_ov_event && !mon2_uv_event) |=> !mon2_to_safe && !mon2_to_reset)
        else $error("request without event");
    // Accepted writes must land as written, reserved bits dropped
    cfg_wr_a: assert property (@(posedge clk) disable iff (srst)
        wr_cfg_ok |=> second_monitor_response_config == ($past(wr_data) & MPC_M2_MASK))
        else $error("config write lost");
    // Fault and safe clears win over the write, so they are left out here
    pc_wr_a: assert property (@(posedge clk) disable iff (srst)
        (wr_pc_ok && !pc_load && !boost_fault && !lv_buck_fault && !safe_state_entry)
        |=> power_enable_control == ($past(wr_data) & MPC_PC_MASK))
        else $error("power control write lost");
    rst_entry_a: assert property (@(posedge clk) disable iff (srst)
        (reset_state_entry && !safe_state_entry && !boost_fault && !lv_buck_fault)
        |=> (power_enable_control & ~MPC_PC_KEEP) == MPC_PC_RST)
        else $error("power control not set on reset entry");
    cm_entry_a: assert property (@(posedge clk) disable iff (srst)
        reset_state_entry |=> clk_mon_ctrl == MPC_CM_RST)
        else $error("clock monitor not set on reset entry");
    cm_lock_a: assert property (@(posedge clk) disable iff (srst)
        (wr_strobe && reg_sel == MPC_SEL_CLK_MON && ctrl_lock && !reset_state_entry)
        |=> $stable(clk_mon_ctrl))
        else $error("clock monitor changed under lock");
    cm_wr_a: assert property (@(posedge clk) disable iff (srst)
        (wr_cm_ok && !pc_load) |=> clk_mon_ctrl == ($past(wr_data) & MPC_CM_MASK))
        else $error("clock monitor write lost");
    prereg_trip_a: assert property (@(posedge clk) disable iff (srst)
        prereg_protect_off |=> !prereg_on)
        else $error("preregulator on while tripped");
    prereg_wake_a: assert property (@(posedge clk) disable iff (srst)
        (!wake && !wake_latch) |-> !prereg_on)
        else $error("preregulator on without wake");
    cfg_wr_c: cover property (@(posedge clk) disable iff (srst) wr_cfg_ok);
    reset_c: cover property (@(posedge clk) disable iff (srst) mon2_to_reset);
    safe_c: cover property (@(posedge clk) disable iff (srst) safe_state_entry ##1 !boost_on);
    trip_c: cover property (@(posedge clk) disable iff (srst) prereg_protect_off ##1 !prereg_on);
    keep_c: cover property (@(posedge clk) disable iff (srst) reset_state_entry && second_supply_monitor_on);
endmodule : mpc_regs
`default_nettype wire

// >>> tb/mpc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module mpc_host_model (
    input wire logic clk,
    input wire logic [7:0] rd_data,
    output logic wr_strobe,
    output logic rd_strobe,
    output logic [1:0] reg_sel,
    output logic [7:0] wr_data
);
    initial begin
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        reg_sel = 2'h3;
        wr_data = 8'h00;
    end
    // Released data shows the inverse so a stale value never looks valid
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(negedge clk);
        reg_sel = sel;
        wr_data = d;
        wr_strobe = 1'b1;
        @(negedge clk);
        wr_strobe = 1'b0;
        wr_data = ~d;
        reg_sel = 2'h3;
    endtask : wr
    task automatic rd(input logic [1:0] sel, output logic [7:0] q);
        @(negedge clk);
        reg_sel = sel;
        rd_strobe = 1'b1;
        @(negedge clk);
        q = rd_data;
        rd_strobe = 1'b0;
        reg_sel = 2'h3;
    endtask : rd
endmodule : mpc_host_model
`default_nettype wire

// >>> tb/monitor_and_power_control_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module monitor_and_power_control_regs_tb_top;
    logic clk = 1'b0, srst = 1'b1, diag = 1'b0, rse = 1'b0, sse = 1'b0, cfg_lock = 1'b0, ctrl_lock = 1'b0;
    logic ov = 1'b0, uv = 1'b0, bf = 1'b0, lf = 1'b0, wake = 1'b1, wl = 1'b0, poff = 1'b0, rok = 1'b0;
    logic wr_strobe, rd_strobe, to_safe, to_reset, mon1, mon2, boost, lvbuck, pre;
    logic [1:0] reg_sel;
    logic [7:0] wr_data, rd_data, cm;
    int err_total = 0, comparisons = 0;
    logic nvu = 1'b1, nvm = 1'b1;
    mpc_regs i_dut (.clk(clk), .srst(srst), .nv_uv_reset_default(nvu), .nv_mon_on_default(nvm),
        .in_diag_state(diag), .reset_state_entry(rse), .safe_state_entry(sse), .cfg_lock(cfg_lock),
        .ctrl_lock(ctrl_lock), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .reg_sel(reg_sel),
        .wr_data(wr_data), .mon2_ov_event(ov), .mon2_uv_event(uv), .boost_fault(bf), .lv_buck_fault(lf),
        .wake(wake), .wake_latch(wl), .prereg_protect_off(poff), .prereg_restart_ok(rok), .rd_data(rd_data),
        .mon2_to_safe(to_safe), .mon2_to_reset(to_reset), .first_supply_monitor_on(mon1),
        .second_supply_monitor_on(mon2), .boost_on(boost), .lv_buck_on(lvbuck), .clk_mon_ctrl(cm),
        .prereg_on(pre));
    mpc_host_model i_host (.clk(clk), .rd_data(rd_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .reg_sel(reg_sel), .wr_data(wr_data));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [1:0] sel, input logic [7:0] exp);
        logic [7:0] v;
        i_host.rd(sel, v);
        chk(v, exp, "register read");
    endtask : rdchk
    task automatic wrap_up;
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic t_reset;
        rdchk(2'h0, 8'h02);
        rdchk(2'h1, 8'h3a);
        chk(cm, 8'h5c, "clock monitor reset");
        chk({7'h0, pre}, 8'h01, "preregulator default");
        rdchk(2'h3, 8'h00);
    endtask : t_reset
    task automatic t_cfg_gate;
        i_host.wr(2'h0, 8'hff);
        rdchk(2'h0, 8'h02);
        @(negedge clk) {diag, cfg_lock} = 2'b11;
        i_host.wr(2'h0, 8'hff);
        rdchk(2'h0, 8'h02);
        @(negedge clk) cfg_lock = 1'b0;
        i_host.wr(2'h0, 8'hff);
        rdchk(2'h0, 8'h0f);
    endtask : t_cfg_gate
    // Every config value against both event kinds; reset outranks safe
    task automatic t_response;
        logic r, s, o, u;
        for (int k = 0; k < 48; k++) begin
            o = k[5] || k[4];
            u = k[5] || !k[4];
            i_host.wr(2'h0, 8'(k[3:0]));
            @(negedge clk) {ov, uv} = {o, u};
            r = (o && k[0]) || (u && k[1]);
            s = !r && ((o && k[3]) || (u && k[2]));
            @(negedge clk) chk({6'h0, to_reset, to_safe}, {6'h0, r, s}, "event response");
            {ov, uv} = 2'b00;
        end
    endtask : t_response
    task automatic t_power;
        @(negedge clk) ctrl_lock = 1'b1;
        i_host.wr(2'h1, 8'h00);
        i_host.wr(2'h2, 8'h00);
        rdchk(2'h1, 8'h3a);
        chk(cm, 8'h5c, "clock monitor locked");
        @(negedge clk) ctrl_lock = 1'b0;
        i_host.wr(2'h1, 8'h00);
        chk({7'h0, pre}, 8'h01, "preregulator register-proof");
        i_host.wr(2'h2, 8'hff);
        chk({2'h0, mon2, mon1, boost, 1'b0, lvbuck, 1'b0}, 8'h00, "power outputs");
        chk(cm, 8'h5e, "clock monitor write");
        i_host.wr(2'h1, 8'h20);
        @(negedge clk) rse = 1'b1;
        @(negedge clk) rse = 1'b0;
        rdchk(2'h1, 8'h2a);
        rdchk(2'h0, 8'h0f);
        chk(cm, 8'h5c, "clock monitor on reset entry");
        i_host.wr(2'h1, 8'h3a);
        @(negedge clk) sse = 1'b1;
        @(negedge clk) sse = 1'b0;
        rdchk(2'h1, 8'h30);
        i_host.wr(2'h1, 8'h3a);
        @(negedge clk) bf = 1'b1;
        @(negedge clk) bf = 1'b0;
        rdchk(2'h1, 8'h32);
        @(negedge clk) lf = 1'b1;
        @(negedge clk) lf = 1'b0;
        chk({2'h0, mon2, mon1, boost, 1'b0, lvbuck, 1'b0}, 8'h30, "fault clears");
        fork
            i_host.wr(2'h1, 8'h3a);
            begin
                @(negedge clk) sse = 1'b1;
                @(negedge clk) sse = 1'b0;
            end
        join
        rdchk(2'h1, 8'h30);
    endtask : t_power
    task automatic t_prereg;
        @(negedge clk) wake = 1'b0;
        #1 chk({7'h0, pre}, 8'h00, "preregulator off");
        @(negedge clk) wl = 1'b1;
        #1 chk({7'h0, pre}, 8'h01, "preregulator latch");
        @(negedge clk) poff = 1'b1;
        @(negedge clk) chk({7'h0, pre}, 8'h00, "preregulator tripped");
        {poff, rok} = 2'b01;
        repeat (2) @(negedge clk);
        chk({7'h0, pre}, 8'h01, "preregulator restart");
    endtask : t_prereg
    // Second power-on with the nonvolatile defaults low
    task automatic t_nv_reset;
        i_host.wr(2'h2, 8'h00);
        @(negedge clk) {srst, nvu, nvm} = 3'b100;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        rdchk(2'h0, 8'h00);
        rdchk(2'h1, 8'h0a);
        chk(cm, 8'h5c, "clock monitor power-on");
    endtask : t_nv_reset
    initial begin
        #1000000;
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk) srst = 1'b0;
        t_reset();
        t_cfg_gate();
        t_response();
        t_power();
        t_prereg();
        t_nv_reset();
        wrap_up();
    end
endmodule : monitor_and_power_control_regs_tb_top
`default_nettype wire
